//--- verilog/wdlp_pkg.sv
// Constants for the watchdog, clock-failure and low-power supervisor.
// Assumes a single 125 MHz oscillator-derived clock and an AXI4-Lite master.
package wdlp_pkg;
  localparam int CLK_MHZ = 125;
  // Register byte offsets.
  localparam logic [7:0] OFS_KEY = 8'h00;
  localparam logic [7:0] OFS_WDCTL = 8'h04;
  localparam logic [7:0] OFS_WDCNT = 8'h08;
  localparam logic [7:0] OFS_LPCTL = 8'h0c;
  localparam logic [7:0] OFS_WAKESEL = 8'h10;
  localparam logic [7:0] OFS_PLLRATIO = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_ENTER = 8'h1c;
  // Field positions.
  localparam int WDCTL_DIS = 0;
  localparam int WDCTL_IRQ = 1;
  localparam int WDCTL_SBWAKE = 2;
  localparam int ST_MISS = 0;
  localparam int ST_DOG = 1;
  localparam int ST_LIMP = 2;
  localparam int ST_BYP = 3;
  // Reset values.
  localparam logic [2:0] WDCTL_RST = 3'h0;
  localparam logic [7:0] LPCTL_RST = 8'h00;
  localparam logic [31:0] WAKESEL_RST = 32'h0000_0000;
  localparam logic [3:0] PLLRATIO_RST = 4'h0;
  // Watchdog key sequence and pulse width.
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] DOG_MAX = 8'hff;
  localparam logic [9:0] DOG_PULSE_CYCLES = 10'h200;
  // Oscillator is declared missing after this long without an edge.
  localparam int MISS_TIME_NS = 1000;
  localparam logic [9:0] MISS_CYCLES = 10'((MISS_TIME_NS * CLK_MHZ) / 1000);
  // Low time that an interrupt-style exit signal must exceed to be recognised.
  localparam logic [7:0] RECOG_CYCLES = 8'h04;
  localparam int PLL_LOCK_CYCLES = 131072;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Power states, one-hot.
  typedef enum logic [3:0] {
    LP_RUN = 4'b0001,
    LP_IDLE = 4'b0010,
    LP_STBY = 4'b0100,
    LP_HALT = 4'b1000
  } wdlp_state_t;
endpackage

//--- verilog/wdlp_qual.sv
// Low-level qualifier: reports a signal that has stayed low for a set count.
// Assumes its input is already synchronised to the clock.
`timescale 1ns/1ps
module wdlp_qual (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sig_low,
  input wire logic [7:0] limit,
  output logic hit
);
  logic [7:0] cnt_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || !sig_low) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff != 8'hff) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // A zero limit still needs one sampled low cycle.
  assign hit = sig_low && (cnt_ff >= limit);
endmodule

//--- verilog/wdlp_top.sv
// Watchdog, oscillator-failure detector and low-power mode controller.
// Assumes an AXI4-Lite master on aclk and raw pins synchronised here.
// Function
// - Oscillator loss with PLL enabled or bypassed keeps CPU clocked from limp clock.
// - Fallback is armed only after the oscillator has toggled at least once.
// - In PLL bypass the CPU clock source switches to limp clock on loss.
// - The watchdog counter holds while running on the limp clock.
// - Oscillator loss resets the device and sets the missing-clock flag.
// - Counter reaching maximum drives dog_reset_out low for 512 clocks.
// - Writing 0x55 then 0xAA to the key register clears the counter.
// - Expiry gives either a reset or a dog_interrupt, as configured.
// - Watchdog runs in STANDBY; its interrupt wakes STANDBY when enabled.
// - In IDLE the dog interrupt reaches the CPU and ends IDLE.
// - In HALT oscillator and PLL stop, so the watchdog does not run.
// - Mode field 00 is IDLE, 01 STANDBY, 1X HALT.
// - IDLE keeps oscillator, CPU clock and system clock out running.
// - STANDBY stops CPU clock, clock out and peripherals but not watchdog.
// - IDLE exits on reset pin, dog interrupt, enabled interrupt or NMI.
// - Selected port A pins, reset, enabled dog interrupt, debugger, NMI exit STANDBY.
// - Selected wake pins are qualified for a programmed cycle count.
// - HALT exits on reset pin, selected port A pin, NMI or debugger.
// - Exit pins are low-active; all but the reset pin must stay low long enough.
// - Output pins keep their state throughout any low-power mode.
// - The debug port keeps its clock while the CPU clock is stopped.
// - PLL bypass means ratio zero, or relocking after a ratio write.
`timescale 1ns/1ps
module wdlp_top
  import wdlp_pkg::*;
#(
  parameter int PLL_LOCK = PLL_LOCK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_sense,
  input wire logic external_reset_pin_n,
  input wire logic ext_nonmask_irq_n,
  input wire logic debug_wake_n,
  input wire logic [31:0] gpio_a,
  input wire logic cpu_irq_pending,
  output logic dog_reset_out_n,
  output logic dog_interrupt,
  output logic sys_reset_n,
  output logic limp_select,
  output logic cpu_src_limp,
  output logic pll_bypass,
  output logic osc_pll_en,
  output logic cpu_clk_en,
  output logic sysclk_out_en,
  output logic periph_clk_en,
  output logic pin_hold,
  output logic jtag_clk_en,
  output logic cpu_wake
);
  logic aw_held_ff, w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [2:0] wdctl_ff;
  logic [7:0] lpctl_ff;
  logic [31:0] wakesel_ff;
  logic [3:0] pllratio_ff;
  logic miss_flag_ff, dog_flag_ff;
  logic [35:0] sync1_ff, sync2_ff;
  logic osc_prev_ff, osc_seen_ff, clk_fail_ff;
  logic [9:0] miss_cnt_ff;
  logic [7:0] dog_cnt_ff;
  logic key_armed_ff;
  logic [9:0] pulse_cnt_ff;
  logic [17:0] relock_cnt_ff;
  wdlp_state_t state_ff, nxt_state;
  logic wr_fire, key_wr, key_clear, dog_run, dog_expire, fail_start;
  logic gpio_low, gpio_hit, nmi_hit, dbg_hit, rst_low, wake_now;
  logic [7:0] wr_ofs;
  logic [31:0] rd_val;
  logic rd_hit;

  // Raw pins: oscillator sense, reset, NMI, debug and port A.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 36'hf_ffff_fffe;
      sync2_ff <= 36'hf_ffff_fffe;
    end else begin
      sync1_ff <= {gpio_a, debug_wake_n, ext_nonmask_irq_n, external_reset_pin_n, osc_sense};
      sync2_ff <= sync1_ff;
    end
  end

  // AXI4-Lite write channel: address and data taken in either order.
  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_ofs = {awaddr_ff[7:2], 2'b00};
  assign key_wr = wr_fire && (wr_ofs == OFS_KEY) && wstrb_ff[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      // Each ready is kept as the registered inverse of its held flag.
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ofs <= OFS_ENTER && wr_ofs != OFS_WDCNT) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers written by software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdctl_ff <= WDCTL_RST;
      lpctl_ff <= LPCTL_RST;
      wakesel_ff <= WAKESEL_RST;
      pllratio_ff <= PLLRATIO_RST;
    end else if (wr_fire) begin
      if (wr_ofs == OFS_WDCTL && wstrb_ff[0]) begin
        wdctl_ff <= wdata_ff[2:0];
      end
      if (wr_ofs == OFS_LPCTL && wstrb_ff[0]) begin
        lpctl_ff <= wdata_ff[7:0];
      end
      if (wr_ofs == OFS_WAKESEL) begin
        for (int i = 0; i < 4; i++) begin
          if (wstrb_ff[i]) begin
            wakesel_ff[i*8 +: 8] <= wdata_ff[i*8 +: 8];
          end
        end
      end
      if (wr_ofs == OFS_PLLRATIO && wstrb_ff[0]) begin
        pllratio_ff <= wdata_ff[3:0];
      end
    end
  end

  // A ratio write forces bypass until the lock time has passed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relock_cnt_ff <= 18'h0_0000;
    end else if (wr_fire && wr_ofs == OFS_PLLRATIO && wstrb_ff[0]) begin
      relock_cnt_ff <= 18'(PLL_LOCK);
    end else if (relock_cnt_ff != 18'h0_0000) begin
      relock_cnt_ff <= relock_cnt_ff - 18'h0_0001;
    end
  end

  // Oscillator monitor: armed by the first edge seen after reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_prev_ff <= 1'b0;
      osc_seen_ff <= 1'b0;
      miss_cnt_ff <= 10'h000;
      clk_fail_ff <= 1'b0;
    end else begin
      osc_prev_ff <= sync2_ff[0];
      if (sync2_ff[0] != osc_prev_ff) begin
        osc_seen_ff <= 1'b1;
        miss_cnt_ff <= 10'h000;
        clk_fail_ff <= 1'b0;
      end else if (osc_seen_ff && state_ff != LP_HALT) begin
        if (miss_cnt_ff == MISS_CYCLES) begin
          clk_fail_ff <= 1'b1;
        end else begin
          miss_cnt_ff <= miss_cnt_ff + 10'h001;
        end
      end
    end
  end

  assign fail_start = osc_seen_ff && !clk_fail_ff && state_ff != LP_HALT &&
                      sync2_ff[0] == osc_prev_ff && miss_cnt_ff == MISS_CYCLES;

  // Watchdog key sequence.
  assign key_clear = key_wr && wdata_ff[7:0] == KEY_SECOND && key_armed_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_armed_ff <= 1'b0;
    end else if (key_wr) begin
      key_armed_ff <= (wdata_ff[7:0] == KEY_FIRST);
    end
  end

  // Watchdog counter: frozen on limp clock, in HALT, or when disabled.
  assign dog_run = !wdctl_ff[WDCTL_DIS] && !clk_fail_ff && state_ff != LP_HALT;
  assign dog_expire = dog_run && !key_clear && dog_cnt_ff == DOG_MAX;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dog_cnt_ff <= 8'h00;
    end else if (key_clear) begin
      dog_cnt_ff <= 8'h00;
    end else if (dog_run) begin
      dog_cnt_ff <= dog_cnt_ff + 8'h01;
    end
  end

  // Expiry response and the reset pulse shared with oscillator failure.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dog_interrupt <= 1'b0;
      dog_reset_out_n <= 1'b1;
      sys_reset_n <= 1'b1;
      pulse_cnt_ff <= 10'h000;
    end else begin
      dog_interrupt <= dog_expire && wdctl_ff[WDCTL_IRQ];
      if (dog_expire && !wdctl_ff[WDCTL_IRQ]) begin
        pulse_cnt_ff <= DOG_PULSE_CYCLES - 10'h001;
        dog_reset_out_n <= 1'b0;
        sys_reset_n <= 1'b0;
      end else if (fail_start) begin
        pulse_cnt_ff <= DOG_PULSE_CYCLES - 10'h001;
        sys_reset_n <= 1'b0;
      end else if (pulse_cnt_ff != 10'h000) begin
        pulse_cnt_ff <= pulse_cnt_ff - 10'h001;
      end else begin
        dog_reset_out_n <= 1'b1;
        sys_reset_n <= 1'b1;
      end
    end
  end

  // Status flags: a new event wins over a write-one-to-clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      miss_flag_ff <= 1'b0;
      dog_flag_ff <= 1'b0;
    end else begin
      if (fail_start) begin
        miss_flag_ff <= 1'b1;
      end else if (wr_fire && wr_ofs == OFS_STATUS && wstrb_ff[0] && wdata_ff[ST_MISS]) begin
        miss_flag_ff <= 1'b0;
      end
      if (dog_expire) begin
        dog_flag_ff <= 1'b1;
      end else if (wr_fire && wr_ofs == OFS_STATUS && wstrb_ff[0] && wdata_ff[ST_DOG]) begin
        dog_flag_ff <= 1'b0;
      end
    end
  end

  // Exit sources, all low-active.
  assign rst_low = !sync2_ff[1];
  assign gpio_low = |(~sync2_ff[35:4] & wakesel_ff);

  wdlp_qual u_gpio_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_low(gpio_low),
    .limit({2'b00, lpctl_ff[7:2]}),
    .hit(gpio_hit)
  );

  wdlp_qual u_nmi_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_low(!sync2_ff[2]),
    .limit(RECOG_CYCLES),
    .hit(nmi_hit)
  );

  wdlp_qual u_dbg_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_low(!sync2_ff[3]),
    .limit(RECOG_CYCLES),
    .hit(dbg_hit)
  );

  // A low pulse no longer than its qualifier limit never hits, so the mode is kept; the reset pin is unqualified.
  always_comb begin
    nxt_state = state_ff;
    wake_now = 1'b0;
    unique case (state_ff)
      LP_RUN: begin
        if (wr_fire && wr_ofs == OFS_ENTER) begin
          if (lpctl_ff[1]) begin
            nxt_state = LP_HALT;
          end else if (lpctl_ff[0]) begin
            nxt_state = LP_STBY;
          end else begin
            nxt_state = LP_IDLE;
          end
        end
      end
      LP_IDLE: begin
        wake_now = rst_low || dog_interrupt || cpu_irq_pending || nmi_hit;
      end
      LP_STBY: begin
        wake_now = rst_low || (dog_interrupt && wdctl_ff[WDCTL_SBWAKE]) || gpio_hit ||
                   dbg_hit || nmi_hit;
      end
      LP_HALT: begin
        wake_now = rst_low || gpio_hit || nmi_hit || dbg_hit;
      end
    endcase
    if (wake_now) begin
      nxt_state = LP_RUN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= LP_RUN;
      cpu_wake <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cpu_wake <= wake_now;
    end
  end

  // Clock gating and pin hold follow the next state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clk_en <= 1'b1;
      sysclk_out_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_pll_en <= 1'b1;
      pin_hold <= 1'b0;
      jtag_clk_en <= 1'b1;
    end else begin
      cpu_clk_en <= nxt_state == LP_RUN || nxt_state == LP_IDLE;
      sysclk_out_en <= nxt_state == LP_RUN || nxt_state == LP_IDLE;
      periph_clk_en <= nxt_state == LP_RUN || nxt_state == LP_IDLE;
      osc_pll_en <= nxt_state != LP_HALT;
      pin_hold <= nxt_state != LP_RUN;
      jtag_clk_en <= 1'b1;
    end
  end

  // Clock source selection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_bypass <= 1'b1;
      limp_select <= 1'b0;
      cpu_src_limp <= 1'b0;
    end else begin
      pll_bypass <= pllratio_ff == 4'h0 || relock_cnt_ff != 18'h0_0000;
      limp_select <= clk_fail_ff;
      cpu_src_limp <= clk_fail_ff && pll_bypass;
    end
  end

  // AXI4-Lite read channel.
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      OFS_KEY, OFS_ENTER: rd_val = 32'h0000_0000;
      OFS_WDCTL: rd_val = {29'h0, wdctl_ff};
      OFS_WDCNT: rd_val = {24'h0, dog_cnt_ff};
      OFS_LPCTL: rd_val = {24'h0, lpctl_ff};
      OFS_WAKESEL: rd_val = wakesel_ff;
      OFS_PLLRATIO: rd_val = {28'h0, pllratio_ff};
      OFS_STATUS: rd_val = {24'h0, state_ff, pll_bypass, clk_fail_ff, dog_flag_ff,
                            miss_flag_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

//--- sim/wdlp_top_assertions.sv
// Concurrent checks on the supervisor's outputs, bound to the top module.
// Assumes one clock domain, aclk, with a synchronous active-low reset.
`timescale 1ns/1ps
module wdlp_top_assertions
  import wdlp_pkg::*;
#(
  parameter int PLL_LOCK = PLL_LOCK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dog_reset_out_n,
  input wire logic dog_interrupt,
  input wire logic sys_reset_n,
  input wire logic limp_select,
  input wire logic cpu_src_limp,
  input wire logic pll_bypass,
  input wire logic osc_pll_en,
  input wire logic cpu_clk_en,
  input wire logic sysclk_out_en,
  input wire logic periph_clk_en,
  input wire logic pin_hold,
  input wire logic jtag_clk_en,
  input wire logic cpu_wake
);
  logic [9:0] low_cnt_ff;
  logic [9:0] nxt_low_cnt;
  // Counting low cycles lets the pulse width be judged without a long repetition.
  assign nxt_low_cnt = dog_reset_out_n ? 10'h000 : low_cnt_ff + 10'h001;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_ff <= 10'h000;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pulse_len; $rose(dog_reset_out_n) |-> low_cnt_ff == DOG_PULSE_CYCLES; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("dog reset width wrong");
  property p_sys_dog; $fell(dog_reset_out_n) |-> !sys_reset_n; endproperty
  a_sys_dog: assert property (p_sys_dog) else $error("dog reset not on system");
  property p_irq_excl; dog_interrupt |-> dog_reset_out_n; endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("irq and reset together");
  property p_irq_pulse; dog_interrupt |=> !dog_interrupt; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("dog irq too long");
  property p_limp_src; cpu_src_limp |-> limp_select && pll_bypass; endproperty
  a_limp_src: assert property (p_limp_src) else $error("limp source wrong");
  property p_limp_rst; $rose(limp_select) |-> ##[0:2] !sys_reset_n; endproperty
  a_limp_rst: assert property (p_limp_rst) else $error("no reset on clock loss");
  property p_stby; !cpu_clk_en |-> !sysclk_out_en && !periph_clk_en && pin_hold; endproperty
  a_stby: assert property (p_stby) else $error("standby gating wrong");
  property p_halt; !osc_pll_en |-> !cpu_clk_en && pin_hold; endproperty
  a_halt: assert property (p_halt) else $error("halt gating wrong");
  property p_jtag; !cpu_clk_en |-> jtag_clk_en; endproperty
  a_jtag: assert property (p_jtag) else $error("debug clock stopped");
  property p_wake; $fell(pin_hold) |-> cpu_wake && cpu_clk_en; endproperty
  a_wake: assert property (p_wake) else $error("pins released without wake");
endmodule
bind wdlp_top wdlp_top_assertions #(.PLL_LOCK(PLL_LOCK)) i_chk (.aclk(aclk),
  .aresetn(aresetn), .dog_reset_out_n(dog_reset_out_n), .dog_interrupt(dog_interrupt),
  .sys_reset_n(sys_reset_n), .limp_select(limp_select), .cpu_src_limp(cpu_src_limp),
  .pll_bypass(pll_bypass), .osc_pll_en(osc_pll_en), .cpu_clk_en(cpu_clk_en),
  .sysclk_out_en(sysclk_out_en), .periph_clk_en(periph_clk_en), .pin_hold(pin_hold),
  .jtag_clk_en(jtag_clk_en), .cpu_wake(cpu_wake));

//--- sim/wdlp_top_tb.sv
// Self-checking bench for the watchdog, clock-failure and low-power supervisor.
// Assumes the bench alone drives every input; the oscillator is a toggling level.
`timescale 1ns/1ps
module wdlp_top_tb;
  import wdlp_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, gpio_a = 32'hffffffff, rdata, rd, c0;
  logic osc_sense = 0, osc_run = 0, rst_n = 1, nmi_n = 1, dbg_n = 1, irq_p = 0;
  logic awready, wready, bvalid, arready, rvalid, dog_n, dog_irq, sys_n, limp, src_limp, byp;
  logic osc_en, cpu_en, sclk_en, per_en, hold, jtag_en, wake;
  logic [1:0] bresp, rresp;
  int err_total = 0, check_count = 0, low_n = 0;
  always #4 aclk = ~aclk;
  always @(posedge aclk) if (osc_run) osc_sense <= ~osc_sense;
  always @(negedge aclk) if (!dog_n) low_n++;
  wdlp_top #(.PLL_LOCK(64)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .osc_sense(osc_sense),
    .external_reset_pin_n(rst_n), .ext_nonmask_irq_n(nmi_n), .debug_wake_n(dbg_n),
    .gpio_a(gpio_a), .cpu_irq_pending(irq_p), .dog_reset_out_n(dog_n),
    .dog_interrupt(dog_irq), .sys_reset_n(sys_n), .limp_select(limp),
    .cpu_src_limp(src_limp), .pll_bypass(byp), .osc_pll_en(osc_en), .cpu_clk_en(cpu_en),
    .sysclk_out_en(sclk_en), .periph_clk_en(per_en), .pin_hold(hold),
    .jtag_clk_en(jtag_en), .cpu_wake(wake));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask
  // Handshakes are judged at the falling edge, where ready and valid are settled.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ta = 0;
    tw = 0;
    tb = 0;
    while (!tb) begin
      @(negedge aclk);
      ta = ta | (awvalid & awready);
      tw = tw | (wvalid & wready);
      tb = bvalid;
      if (tb) chk(bresp, er);
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    @(negedge aclk);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ta = 0;
    tr = 0;
    while (!tr) begin
      @(negedge aclk);
      ta = ta | (arvalid & arready);
      tr = rvalid;
      if (tr) rd = rdata;
      if (tr) chk(rresp, er);
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    @(negedge aclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a, RESP_OKAY);
    chk(rd, e);
  endtask
  task automatic key(input logic [7:0] k);
    wr(OFS_KEY, {24'h0, k}, RESP_OKAY);
  endtask
  task automatic waitfor(input int s, input logic v, input int lim);
    logic cur;
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      cur = (s == 0) ? dog_n : (s == 1) ? dog_irq : (s == 2) ? limp : wake;
      n++;
    end while (cur !== v && n < lim);
    chk(cur, v);
  endtask
  task automatic src(input int s, input logic on);
    @(posedge aclk);
    case (s)
      0: nmi_n <= !on;
      1: gpio_a[5] <= !on;
      2: dbg_n <= !on;
      3: irq_p <= on;
      4: rst_n <= !on;
      default: ;
    endcase
  endtask
  task automatic lp(input logic [1:0] m, input int s);
    wr(OFS_LPCTL, {24'h0, 6'h08, m}, RESP_OKAY);
    wr(OFS_ENTER, 32'h0, RESP_OKAY);
    chk(hold, 1'b1);
    chk({cpu_en, sclk_en, per_en}, {3{m == 2'b00}});
    chk(osc_en, !m[1]);
    chk(jtag_en, 1'b1);
    // A one-cycle low on an exit line is too short to be recognised.
    src(0, 1'b1);
    src(0, 1'b0);
    cyc(12);
    chk(hold, 1'b1);
    src(s, 1'b1);
    waitfor(3, 1'b1, 400);
    src(s, 1'b0);
    cyc(2);
    chk({hold, cpu_en}, 2'b01);
  endtask
  task automatic t_regs();
    rchk(OFS_WDCTL, 32'h0);
    wr(OFS_WDCTL, 32'h1, RESP_OKAY);
    rchk(OFS_LPCTL, 32'h0);
    rchk(OFS_WAKESEL, 32'h0);
    rchk(OFS_PLLRATIO, 32'h0);
    rchk(OFS_STATUS, 32'h18);
    rchk(OFS_KEY, 32'h0);
    rdr(8'h20, RESP_SLVERR);
    wr(OFS_WDCNT, 32'h0, RESP_SLVERR);
    $display("registers done");
  endtask
  task automatic t_key();
    rdr(OFS_WDCNT, RESP_OKAY);
    c0 = rd;
    key(KEY_FIRST);
    key(8'h11);
    key(KEY_SECOND);
    rchk(OFS_WDCNT, c0);
    key(KEY_FIRST);
    key(KEY_SECOND);
    rchk(OFS_WDCNT, 32'h0);
    $display("key done");
  endtask
  task automatic t_dog();
    low_n = 0;
    wr(OFS_WDCTL, 32'h0, RESP_OKAY);
    waitfor(0, 1'b0, 300);
    chk(sys_n, 1'b0);
    wr(OFS_WDCTL, 32'h1, RESP_OKAY);
    waitfor(0, 1'b1, 600);
    chk(low_n, 512);
    wr(OFS_WDCTL, 32'h2, RESP_OKAY);
    waitfor(1, 1'b1, 300);
    chk(dog_n, 1'b1);
    wr(OFS_WDCTL, 32'h1, RESP_OKAY);
    rchk(OFS_STATUS, 32'h1a);
    $display("watchdog done");
  endtask
  task automatic t_lp();
    wr(OFS_WAKESEL, 32'h20, RESP_OKAY);
    key(KEY_FIRST);
    key(KEY_SECOND);
    wr(OFS_WDCTL, 32'h6, RESP_OKAY);
    lp(2'b01, 5);
    wr(OFS_WDCTL, 32'h1, RESP_OKAY);
    lp(2'b00, 3);
    lp(2'b01, 1);
    lp(2'b10, 2);
    lp(2'b11, 0);
    lp(2'b00, 4);
    $display("low power done");
  endtask
  task automatic t_osc();
    key(KEY_FIRST);
    key(KEY_SECOND);
    wr(OFS_WDCTL, 32'h0, RESP_OKAY);
    @(posedge aclk);
    osc_run <= 1'b0;
    waitfor(2, 1'b1, 200);
    cyc(2);
    chk(sys_n, 1'b0);
    chk(src_limp, 1'b1);
    rdr(OFS_WDCNT, RESP_OKAY);
    c0 = rd;
    cyc(20);
    rchk(OFS_WDCNT, c0);
    rchk(OFS_STATUS, 32'h1f);
    @(posedge aclk);
    osc_run <= 1'b1;
    waitfor(2, 1'b0, 20);
    wr(OFS_WDCTL, 32'h1, RESP_OKAY);
    $display("clock loss done");
  endtask
  task automatic t_pll();
    wr(OFS_PLLRATIO, 32'h3, RESP_OKAY);
    chk(byp, 1'b1);
    cyc(80);
    chk(byp, 1'b0);
    wr(OFS_PLLRATIO, 32'h0, RESP_OKAY);
    chk(byp, 1'b1);
    $display("pll done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(8 * 30000);
    err_total++;
    $display("MISMATCH %0t: run timed out", $time);
    summarize();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // The oscillator has not toggled yet, so no failure may be reported.
    cyc(135);
    chk(limp, 1'b0);
    @(posedge aclk);
    osc_run <= 1'b1;
    t_regs();
    t_key();
    t_dog();
    t_lp();
    t_osc();
    t_pll();
    summarize();
  end
endmodule
